// ### host_port_map.vh
`ifndef HOST_PORT_MAP_VH
`define HOST_PORT_MAP_VH

// Cycle type codes on cycle_type_select
`define CT_CONTROL 2'h0
`define CT_DATA_AUTO 2'h1
`define CT_ADDRESS 2'h2
`define CT_DATA_FIXED 2'h3

// control_reg field positions
`define CTRL_ORDER_BIT 0
`define CTRL_ORDER_STAT_BIT 8
`define CTRL_PREFETCH_BIT 4
`define CTRL_ORDER_RESET 1'h0

// FIFO and burst geometry
`define FIFO_ADDR_BITS 3
`define FIFO_WORD_BITS 32
`define BURST_WORDS 3'h4

// Wait held per address halfword, in core clock cycles
`define ADDR_WAIT_CYC 3'h2

// Reset values
`define ADDR_RESET 32'h00000000

`endif

// ### host_port_ready.v
`timescale 1ns/1ps
`include "host_port_map.vh"

// Notes on behaviour
// - Read ready only when read data available
// - Write ready only when write data latchable
// - Strobe rise while not ready ends cycle
// - New control latched even while not ready
// - Ready low only with chip select asserted
// - Control/address reads never wait; control reads ignore halfword
// - Address write halfwords wait; fixed read waits first
// - Auto reads wait only on first halfword
// - Control writes never wait, single halfword
// - Fixed data write waits on second halfword
// - Auto writes wait only when FIFO full
// - Address write drains write FIFO first
// - Full write or empty read FIFO stalls
// - Separate eight-word 32-bit read/write FIFOs
// - DMA moves four-word bursts
// - Address write flushes read FIFO after DMA
// - Auto read starts two bursts, waits data
// - Burst again when four entries free
// - Writing prefetch bit one starts prefetching
// - Fixed read flushes, single word, stops prefetch
// - Controls sampled at strobe falling edge
// - Cycle type encoding of access kinds
module host_port_ready #(
  parameter AW = `FIFO_ADDR_BITS,
  parameter DW = `FIFO_WORD_BITS
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire host_chip_select_n_in,
  input wire internal_strobe_n_in,
  input wire [1:0] cycle_type_select_in,
  input wire read_not_write_in,
  input wire halfword_select_in,
  input wire [15:0] host_data_in,
  input wire [DW-1:0] mem_rdata_in,
  input wire mem_rvalid_in,
  input wire mem_wready_in,
  output reg host_ready_out,
  output reg [15:0] host_data_out,
  output reg mem_req_out,
  output reg mem_we_out,
  output reg [31:0] mem_addr_out,
  output reg [2:0] mem_len_out,
  output reg [DW-1:0] mem_wdata_out
);

  localparam H_IDLE = 1'b0;
  localparam H_ACTIVE = 1'b1;
  localparam D_IDLE = 2'h0;
  localparam D_WRITE = 2'h1;
  localparam D_READ = 2'h2;
  localparam SW = 22;

  // Halfword of a word, first or second, under the order bit
  function [15:0] pick_half;
    input [31:0] word;
    input second;
    input order;
    begin
      pick_half = (second ^ order) ? word[15:0] : word[31:16];
    end
  endfunction

  // Places a halfword into a word under the order bit
  function [31:0] put_half;
    input [31:0] word;
    input [15:0] half;
    input second;
    input order;
    begin
      if (second ^ order)
        put_half = {word[31:16], half};
      else
        put_half = {half, word[15:0]};
    end
  endfunction

  reg [SW-1:0] s1_q, s2_q, s3_q;
  reg strb_lvl_q, cs_lvl_q;
  reg hstate_q;
  reg [1:0] ct_q;
  reg rnw_q, hw_q;
  reg order_q;
  reg [31:0] addr_q, raddr_q, waddr_q, whold_q;
  reg [2:0] hold_cnt_q;
  reg prefetch_q, rflush_q, rsingle_q, wflush_q, wsingle_q;
  reg [1:0] dstate_q;
  reg [2:0] dcnt_q;
  reg dsingle_q;
  reg [DW-1:0] rf_mem [0:(1<<AW)-1];
  reg [DW-1:0] wf_mem [0:(1<<AW)-1];
  reg [AW:0] rf_wr_q, rf_rd_q, wf_wr_q, wf_rd_q;
  wire [SW-1:0] pins;
  wire [AW:0] rf_count, wf_count;
  wire rf_empty, wf_empty, wf_full;
  wire strb_fall, strb_rise, wf_pop, rf_push, wstart;
  wire [15:0] data_s;
  reg wait_c;

  assign pins = {host_chip_select_n_in, internal_strobe_n_in,
    cycle_type_select_in, read_not_write_in, halfword_select_in,
    host_data_in};
  assign data_s = s3_q[15:0];

  // Three-stage synchroniser on every host pin
  always @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      s1_q <= {SW{1'b1}};
      s2_q <= {SW{1'b1}};
      s3_q <= {SW{1'b1}};
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Levels move only when stages two and three agree
  always @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      strb_lvl_q <= 1'b1;
      cs_lvl_q <= 1'b1;
    end
    else
    begin
      if (s2_q[20] == s3_q[20])
        strb_lvl_q <= s3_q[20];
      if (s2_q[21] == s3_q[21])
        cs_lvl_q <= s3_q[21];
    end
  end

  assign strb_fall = strb_lvl_q && s2_q[20] == s3_q[20] && !s3_q[20];
  assign strb_rise = !strb_lvl_q && s2_q[20] == s3_q[20] && s3_q[20];

  // Both FIFOs are eight words of 32 bits, pointers carry a wrap bit
  assign rf_count = rf_wr_q - rf_rd_q;
  assign wf_count = wf_wr_q - wf_rd_q;
  assign rf_empty = rf_count == {(AW+1){1'b0}};
  assign wf_empty = wf_count == {(AW+1){1'b0}};
  assign wf_full = wf_count[AW];
  assign wf_pop = dstate_q == D_WRITE && mem_wready_in;
  assign rf_push = dstate_q == D_READ && mem_rvalid_in;
  assign wstart = wf_count >= {1'b0, `BURST_WORDS} ||
    (wflush_q && !wf_empty);

  // Wait condition of the cycle now in progress
  always @*
  begin
    wait_c = 1'b0;
    if (hstate_q == H_ACTIVE)
    begin
      case (ct_q)
        `CT_CONTROL: wait_c = 1'b0;
        `CT_ADDRESS:
          // Drain posted writes, then a short hold per halfword
          wait_c = !rnw_q && (!wf_empty || dstate_q == D_WRITE ||
            hold_cnt_q != 3'h0);
        `CT_DATA_AUTO:
          if (rnw_q)
            wait_c = !hw_q && (rf_empty || rflush_q);
          else
            wait_c = hw_q && wf_full;
        default:
          if (rnw_q)
            wait_c = !hw_q && (rf_empty || rflush_q || rsingle_q);
          else
            wait_c = hw_q && (!wf_empty || wflush_q);
      endcase
    end
  end

  // Host cycle tracking; the strobe rise always ends the cycle
  always @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      hstate_q <= H_IDLE;
      ct_q <= `CT_CONTROL;
      rnw_q <= 1'b1;
      hw_q <= 1'b0;
      hold_cnt_q <= 3'h0;
      host_ready_out <= 1'b1;
    end
    else
    begin
      // Wait state only while the chip is selected
      host_ready_out <= !(wait_c && !cs_lvl_q);
      if (strb_fall)
      begin
        hstate_q <= H_ACTIVE;
        ct_q <= s3_q[19:18];
        rnw_q <= s3_q[17];
        hw_q <= s3_q[16];
        hold_cnt_q <= `ADDR_WAIT_CYC;
      end
      else if (strb_rise)
        hstate_q <= H_IDLE;
      else if (hold_cnt_q != 3'h0 && wf_empty && dstate_q != D_WRITE)
        hold_cnt_q <= hold_cnt_q - 3'h1;
    end
  end

  // Register-side effects of host cycles
  always @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      order_q <= `CTRL_ORDER_RESET;
      addr_q <= `ADDR_RESET;
      whold_q <= 32'h00000000;
      prefetch_q <= 1'b0;
    end
    else
    begin
      if (strb_fall && s3_q[19:18] == `CT_DATA_AUTO && s3_q[17])
        prefetch_q <= 1'b1;
      else if (strb_fall && s3_q[19:18] == `CT_DATA_FIXED && s3_q[17])
        prefetch_q <= 1'b0;
      else if (strb_rise && !rnw_q)
      begin
        case (ct_q)
          `CT_CONTROL:
          begin
            order_q <= data_s[`CTRL_ORDER_BIT];
            if (data_s[`CTRL_PREFETCH_BIT])
              prefetch_q <= 1'b1;
          end
          `CT_ADDRESS:
          begin
            addr_q <= put_half(addr_q, data_s, hw_q, order_q);
            if (hw_q)
              prefetch_q <= 1'b0;
          end
          default:
            whold_q <= put_half(whold_q, data_s, hw_q, order_q);
        endcase
      end
    end
  end

  // Read data presented to the host, one halfword at a time
  always @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      host_data_out <= 16'h0000;
    else
    begin
      case (ct_q)
        `CT_CONTROL:
        begin
          host_data_out <= 16'h0000;
          host_data_out[`CTRL_ORDER_BIT] <= order_q;
          host_data_out[`CTRL_ORDER_STAT_BIT] <= order_q;
        end
        `CT_ADDRESS: host_data_out <= pick_half(addr_q, hw_q, order_q);
        default:
          host_data_out <= pick_half(rf_mem[rf_rd_q[AW-1:0]], hw_q,
            order_q);
      endcase
    end
  end

  // Flush and single-word requests raised by host cycles
  always @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      rflush_q <= 1'b0;
      rsingle_q <= 1'b0;
      wflush_q <= 1'b0;
      wsingle_q <= 1'b0;
    end
    else
    begin
      if (strb_fall && s3_q[19:18] == `CT_DATA_FIXED && s3_q[17] &&
        !s3_q[16])
      begin
        rflush_q <= 1'b1;
        rsingle_q <= 1'b1;
      end
      else if (strb_rise && !rnw_q && ct_q == `CT_ADDRESS && hw_q)
        rflush_q <= 1'b1;
      else if (rflush_q && dstate_q == D_IDLE && !wstart)
        rflush_q <= 1'b0;
      else if (rsingle_q && dstate_q == D_READ && dsingle_q)
        rsingle_q <= 1'b0;
      // A fixed write or address write forces posted data out
      if (strb_rise && !rnw_q && hw_q && (ct_q == `CT_DATA_FIXED ||
        ct_q == `CT_ADDRESS))
        wflush_q <= 1'b1;
      else if (strb_fall && !s3_q[17] && s3_q[19:18] == `CT_ADDRESS)
        wflush_q <= 1'b1;
      else if (wf_empty && dstate_q == D_IDLE)
        wflush_q <= 1'b0;
      if (strb_rise && !rnw_q && hw_q && ct_q == `CT_DATA_FIXED)
        wsingle_q <= 1'b1;
      else if (wf_empty && dstate_q == D_IDLE)
        wsingle_q <= 1'b0;
    end
  end

  // FIFO storage; the pointers live in the engine process
  always @(posedge core_clk_in)
  begin
    if (rf_push)
      rf_mem[rf_wr_q[AW-1:0]] <= mem_rdata_in;
    if (strb_rise && !rnw_q && hw_q && (ct_q == `CT_DATA_AUTO ||
      ct_q == `CT_DATA_FIXED))
      wf_mem[wf_wr_q[AW-1:0]] <= put_half(whold_q, data_s, hw_q,
        order_q);
  end

  // DMA engine: four-word bursts, flushes and single words
  always @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      dstate_q <= D_IDLE;
      dcnt_q <= 3'h0;
      dsingle_q <= 1'b0;
      rf_wr_q <= {(AW+1){1'b0}};
      rf_rd_q <= {(AW+1){1'b0}};
      wf_wr_q <= {(AW+1){1'b0}};
      wf_rd_q <= {(AW+1){1'b0}};
      raddr_q <= `ADDR_RESET;
      waddr_q <= `ADDR_RESET;
      mem_req_out <= 1'b0;
      mem_we_out <= 1'b0;
      mem_addr_out <= `ADDR_RESET;
      mem_len_out <= 3'h0;
    end
    else
    begin
      mem_req_out <= 1'b0;
      // Host push and pop on the second halfword's strobe rise
      if (strb_rise && !rnw_q && hw_q && (ct_q == `CT_DATA_AUTO ||
        ct_q == `CT_DATA_FIXED) && !wf_full)
        wf_wr_q <= wf_wr_q + 1'b1;
      if (strb_rise && rnw_q && hw_q && ct_q[0] && !rf_empty &&
        !rflush_q)
        rf_rd_q <= rf_rd_q + 1'b1;
      case (dstate_q)
        D_IDLE:
          if (wstart)
          begin
            dstate_q <= D_WRITE;
            dsingle_q <= wsingle_q;
            dcnt_q <= wf_count[AW] ? `BURST_WORDS :
              (wf_count[AW-1:0] > `BURST_WORDS ? `BURST_WORDS :
              wf_count[AW-1:0]);
            mem_len_out <= wf_count[AW] ? `BURST_WORDS :
              (wf_count[AW-1:0] > `BURST_WORDS ? `BURST_WORDS :
              wf_count[AW-1:0]);
            mem_req_out <= 1'b1;
            mem_we_out <= 1'b1;
            mem_addr_out <= waddr_q;
          end
          else if (rflush_q)
          begin
            rf_wr_q <= {(AW+1){1'b0}};
            rf_rd_q <= {(AW+1){1'b0}};
            if (rsingle_q)
            begin
              dstate_q <= D_READ;
              dsingle_q <= 1'b1;
              dcnt_q <= 3'h1;
              mem_len_out <= 3'h1;
              mem_req_out <= 1'b1;
              mem_we_out <= 1'b0;
              mem_addr_out <= raddr_q;
            end
          end
          else if (prefetch_q &&
            rf_count <= {1'b0, `BURST_WORDS})
          begin
            // Space for four more words: fetch the next run
            dstate_q <= D_READ;
            dsingle_q <= 1'b0;
            dcnt_q <= `BURST_WORDS;
            mem_len_out <= `BURST_WORDS;
            mem_req_out <= 1'b1;
            mem_we_out <= 1'b0;
            mem_addr_out <= raddr_q;
          end
        D_WRITE:
          if (mem_wready_in)
          begin
            wf_rd_q <= wf_rd_q + 1'b1;
            if (!dsingle_q)
              waddr_q <= waddr_q + 32'h00000001;
            dcnt_q <= dcnt_q - 3'h1;
            if (dcnt_q == 3'h1)
              dstate_q <= D_IDLE;
          end
        D_READ:
          if (mem_rvalid_in)
          begin
            rf_wr_q <= rf_wr_q + 1'b1;
            if (!dsingle_q && !rflush_q) // Flush pending: keep new address
              raddr_q <= raddr_q + 32'h00000001;
            dcnt_q <= dcnt_q - 3'h1;
            if (dcnt_q == 3'h1)
              dstate_q <= D_IDLE;
          end
        default: dstate_q <= D_IDLE;
      endcase
      // A new address sets both walking addresses; placed last so that it
      // wins over a burst still stepping the old one
      if (strb_rise && !rnw_q && ct_q == `CT_ADDRESS && hw_q)
      begin
        raddr_q <= put_half(addr_q, data_s, hw_q, order_q);
        waddr_q <= put_half(addr_q, data_s, hw_q, order_q);
      end
    end
  end

  // Head of the write FIFO, looking past a word popped this cycle
  always @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      mem_wdata_out <= {DW{1'b0}};
    else if (wf_pop)
      mem_wdata_out <= wf_mem[wf_rd_q[AW-1:0] + 1'b1];
    else
      mem_wdata_out <= wf_mem[wf_rd_q[AW-1:0]];
  end

endmodule

// ### host_port_ready_properties.sv
`timescale 1ns/1ps
// Watches the host ready pin and the burst requests toward memory
module host_port_ready_properties (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire host_chip_select_n_in,
  input wire [1:0] cycle_type_select_in,
  input wire read_not_write_in,
  input wire mem_rvalid_in,
  input wire host_ready_out,
  input wire mem_req_out,
  input wire mem_we_out,
  input wire [2:0] mem_len_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  reg rdy_q;
  reg rv_q;
  // Remember a landed read word since ready last dropped
  always @(posedge core_clk_in)
  begin
    rdy_q <= host_ready_out;
    if (!rst_n_in)
      rv_q <= 1'b0;
    else if (mem_rvalid_in)
      rv_q <= 1'b1;
    else if (rdy_q && !host_ready_out)
      rv_q <= 1'b0;
  end
  // Long enough for the select synchroniser to settle
  sequence cs_idle;
    host_chip_select_n_in[*6];
  endsequence
  sequence ctl_steady;
    (cycle_type_select_in == 2'h0 && host_ready_out)[*8];
  endsequence
  cs_wait_a: assert property (cs_idle |-> host_ready_out)
    else $error("ready low while chip select idle");
  reset_out_a: assert property ($rose(rst_n_in) |->
    host_ready_out && !mem_req_out)
    else $error("outputs wrong after reset");
  req_pulse_a: assert property (mem_req_out |=> !mem_req_out)
    else $error("burst request longer than one cycle");
  rd_len_a: assert property (mem_req_out && !mem_we_out |->
    mem_len_out == 3'h4 || mem_len_out == 3'h1)
    else $error("read burst length wrong");
  wr_len_a: assert property (mem_req_out && mem_we_out |->
    mem_len_out != 3'h0 && mem_len_out <= 3'h4)
    else $error("write burst length wrong");
  cmd_hold_a: assert property (!mem_req_out |->
    $stable(mem_len_out) && $stable(mem_we_out))
    else $error("burst command moved between requests");
  ctl_nowait_a: assert property (ctl_steady |=> host_ready_out)
    else $error("control access waited");
  rd_data_a: assert property ($rose(host_ready_out) &&
    read_not_write_in && cycle_type_select_in[0] |-> rv_q)
    else $error("read ready before data landed");
endmodule

bind host_port_ready host_port_ready_properties i_props (
  .core_clk_in, .rst_n_in, .host_chip_select_n_in, .cycle_type_select_in,
  .read_not_write_in, .mem_rvalid_in, .host_ready_out, .mem_req_out,
  .mem_we_out, .mem_len_out
);

// ### mem_model.sv
`timescale 1ns/1ps
// Memory at the DMA side; each word's content follows from its address
module mem_model (
  input wire core_clk_in,
  input wire slow_in,
  input wire mem_req_out,
  input wire mem_we_out,
  input wire [31:0] mem_addr_out,
  input wire [2:0] mem_len_out,
  input wire [31:0] mem_wdata_out,
  output logic [31:0] mem_rdata_in = 32'h0,
  output logic mem_rvalid_in = 1'b0,
  output logic mem_wready_in = 1'b0
);
  logic [31:0] w_q[$];
  logic [31:0] cur = 32'h0;
  logic [31:0] tk = 32'h0;
  logic we = 1'b0;
  int left = 0;
  int gap = 0;
  // Idle read data toggles, so a word taken without valid shows up
  always @(posedge core_clk_in)
  begin
    mem_rvalid_in <= 1'b0;
    mem_wready_in <= 1'b0;
    mem_rdata_in <= ~mem_rdata_in;
    if (mem_wready_in)
    begin
      w_q.push_back(tk);
      w_q.push_back(mem_wdata_out);
    end
    if (mem_req_out)
    begin
      left <= mem_len_out;
      cur <= mem_addr_out;
      we <= mem_we_out;
      gap <= slow_in ? 120 : 1;
    end
    else if (gap > 0)
      gap <= gap - 1;
    else if (left > 0)
    begin
      left <= left - 1;
      cur <= cur + 32'h1;
      tk <= cur;
      mem_wready_in <= we;
      mem_rvalid_in <= !we;
      // Slow memory stalls before every word, so bursts drain slowly
      gap <= slow_in ? 120 : 0;
      if (!we)
        mem_rdata_in <= {cur[15:0] ^ 16'h5A3C, cur[15:0]};
    end
  end
endmodule

// ### tb.sv
`timescale 1ns/1ps
module tb;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cs_n = 1'b1;
  logic strb_n = 1'b1;
  logic [1:0] ct = 2'h0;
  logic rnw = 1'b0;
  logic hw = 1'b0;
  logic [15:0] hd = 16'h0000;
  logic slow = 1'b0;
  logic ord = 1'b0;
  logic [31:0] rnd = 32'h00010059;
  logic [31:0] w;
  logic [31:0] a;
  logic [15:0] hr;
  logic [31:0] exp_q[$];
  int waited;
  int wait0;
  int num_errors = 0;
  int tests_run = 0;
  int rd_reqs = 0;
  wire rdy, req, we, rv, wr;
  wire [15:0] hq;
  wire [2:0] len;
  wire [31:0] ma, rd, wd;

  host_port_ready i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .host_chip_select_n_in(cs_n), .internal_strobe_n_in(strb_n),
    .cycle_type_select_in(ct), .read_not_write_in(rnw),
    .halfword_select_in(hw), .host_data_in(hd), .mem_rdata_in(rd),
    .mem_rvalid_in(rv), .mem_wready_in(wr), .host_ready_out(rdy),
    .host_data_out(hq), .mem_req_out(req), .mem_we_out(we),
    .mem_addr_out(ma), .mem_len_out(len), .mem_wdata_out(wd));
  mem_model i_mem (.core_clk_in(core_clk_in), .slow_in(slow),
    .mem_req_out(req), .mem_we_out(we), .mem_addr_out(ma),
    .mem_len_out(len), .mem_wdata_out(wd), .mem_rdata_in(rd),
    .mem_rvalid_in(rv), .mem_wready_in(wr));

  // Clock at 10 MHz
  initial
    forever #50 core_clk_in = ~core_clk_in;

  // Read bursts seen on the memory side
  always @(posedge core_clk_in)
    if (req === 1'b1 && we === 1'b0)
      rd_reqs++;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [31:0] mem_word(input logic [31:0] ad);
    mem_word = {ad[15:0] ^ 16'h5A3C, ad[15:0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    if (num_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // One halfword: strobe held until ready is seen high, wait cycles counted
  task automatic half(input logic [1:0] t, input logic r, input logic h,
    input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    waited = 0;
    cs_n <= 1'b0;
    strb_n <= 1'b0;
    ct <= t;
    rnw <= r;
    hw <= h;
    hd <= d;
    while (n < 6 || (rdy !== 1'b1 && n < 400))
    begin
      @(posedge core_clk_in);
      n++;
      if (rdy !== 1'b1)
        waited++;
    end
    if (n >= 400)
      chk("ready timeout", 32'h0, 32'h1);
    @(posedge core_clk_in);
    q = hq;
    strb_n <= 1'b1;
    cs_n <= 1'b1;
    repeat (6) @(posedge core_clk_in);
  endtask

  task automatic word(input logic [1:0] t, input logic r,
    input logic [31:0] d, output logic [31:0] q);
    logic [15:0] f;
    logic [15:0] s;
    half(t, r, 1'b0, ord ? d[15:0] : d[31:16], f);
    wait0 = waited;
    half(t, r, 1'b1, ord ? d[31:16] : d[15:0], s);
    q = ord ? {s, f} : {f, s};
  endtask

  initial
  begin
    repeat (3) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge core_clk_in);
    // Order bit and prefetch command in one single-halfword write
    half(2'h0, 1'b0, 1'b1, 16'h0011, hr);
    ord = 1'b1;
    chk("ctl write wait", 32'h0, waited);
    half(2'h0, 1'b1, 1'b0, 16'h0000, hr);
    chk("ctl read", 32'h0101, {16'h0, hr});
    half(2'h0, 1'b1, 1'b1, 16'h0000, hr);
    chk("ctl read second", 32'h0101, {16'h0, hr});
    chk("fetch bursts", 32'h2, rd_reqs);
    a = {16'h0, rnd[15:0]};
    word(2'h2, 1'b0, a, w);
    chk("addr wait", 32'h1, {31'h0, wait0 > 0 && waited > 0});
    // Twelve words, so the prefetch must refill past the first two bursts
    for (int i = 0; i < 12; i++)
    begin
      word(2'h1, 1'b1, 32'h0, w);
      chk("auto read", mem_word(a + i), w);
      chk("auto read wait", 32'h0, (i > 0 ? wait0 : 0) + waited);
    end
    word(2'h2, 1'b1, 32'h0, w);
    chk("addr read wait", 32'h0, wait0 + waited);
    chk("addr read", a, w);
    half(2'h0, 1'b0, 1'b0, 16'h0000, hr);
    ord = 1'b0;
    rnd = lfsr(rnd);
    a = {16'h0, rnd[31:16]};
    word(2'h2, 1'b0, a, w);
    word(2'h3, 1'b1, 32'h0, w);
    chk("fixed read", mem_word(a), w);
    chk("fixed read second wait", 32'h0, waited);
    chk("fixed read first wait", 32'h1, {31'h0, wait0 > 0});
    rnd = lfsr(rnd);
    a = {16'h0, rnd[15:0]};
    word(2'h2, 1'b0, a, w);
    // Slow memory lets the write FIFO fill by the ninth word
    slow <= 1'b1;
    for (int i = 0; i < 10; i++)
    begin
      rnd = lfsr(rnd);
      word(2'h1, 1'b0, rnd, w);
      exp_q.push_back(a + i);
      exp_q.push_back(rnd);
      if (i < 8)
        chk("auto write wait", 32'h0, wait0 + waited);
      else if (i == 9)
        chk("full fifo wait", 32'h1, {31'h0, waited > 0});
    end
    slow <= 1'b0;
    word(2'h2, 1'b0, a + 32'h40, w);
    chk("flush before addr", 32'd20, i_mem.w_q.size());
    rnd = lfsr(rnd);
    word(2'h3, 1'b0, rnd, w);
    chk("fixed write first wait", 32'h0, wait0);
    exp_q.push_back(a + 32'h40);
    exp_q.push_back(rnd);
    word(2'h2, 1'b0, a, w);
    chk("write count", exp_q.size(), i_mem.w_q.size());
    foreach (exp_q[i])
      chk("memory write", exp_q[i], i_mem.w_q[i]);
    // A second reset must clear the order bit
    half(2'h0, 1'b0, 1'b0, 16'h0001, hr);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    repeat (5) @(posedge core_clk_in);
    half(2'h0, 1'b1, 1'b0, 16'h0000, hr);
    chk("ctl after reset", 32'h0, {16'h0, hr});
    wrap_up();
  end

  // Cuts a hang short; the tests need under ten thousand cycles
  initial
  begin
    repeat (30000) @(posedge core_clk_in);
    num_errors++;
    wrap_up();
  end
endmodule
